/* common/ram_block_pkg.sv */
// shared constants and types of the small dual-port ram block
package ram_block_pkg;
   // storage geometry
   localparam int total_bits_c = 576;
   localparam int rows_c = 32;
   localparam int row_bits_c = 18;
   localparam int addr_bits_c = 9;
   localparam int row_addr_bits_c = 5;
   localparam int col_bits_c = 5;
   localparam int count_bits_c = 10;
   localparam logic [4:0] lane_data_bits_c = 5'h08; // data bits below each parity bit
   localparam logic [4:0] lane_split_c = 5'h09; // first physical bit of the upper lane
   localparam logic [9:0] depth_narrow_c = 10'h200;
   localparam logic [9:0] depth_w9_c = 10'h040;
   localparam logic [9:0] depth_w18_c = 10'h020;
   // apb map
   localparam int paddr_bits_c = 12;
   localparam logic [11:0] cfg_addr_c = 12'h000;
   localparam logic [11:0] stat_addr_c = 12'h004;
   // config fields
   localparam int cfg_mode_lsb_c = 0;
   localparam int cfg_wwidth_lsb_c = 4;
   localparam int cfg_rwidth_lsb_c = 8;
   localparam int cfg_wsel_bit_c = 12;
   localparam int cfg_rasel_bit_c = 13;
   localparam int cfg_resel_bit_c = 14;
   localparam int cfg_osel_bit_c = 15;
   localparam int cfg_bypass_bit_c = 16;
   localparam logic [31:0] cfg_mask_c = 32'h0001_f777;
   localparam logic [31:0] cfg_reset_c = 32'h0000_0660;
   // status fields
   localparam int stat_count_lsb_c = 0;
   localparam int stat_empty_bit_c = 16;
   localparam int stat_full_bit_c = 17;
   // word organisations and operating modes
   typedef enum logic [2:0] {w1, w2, w4, w8, w9, w16, w18} width_type;
   typedef enum logic [2:0] {mode_sdp, mode_sp, mode_fifo, mode_rom, mode_shift} mode_type;
   // contents loaded at configuration, row r at bits r*18 upward
   localparam logic [total_bits_c-1:0] init_image_c = '0;
endpackage

/* common/mem_port_if.sv */
// port bundle between the block control and its storage array
`timescale 1ns/1ps
interface mem_port_if;
   import ram_block_pkg::*;
   logic we;
   logic [row_addr_bits_c-1:0] waddr;
   logic [row_bits_c-1:0] wdata;
   logic [row_bits_c-1:0] wmask;
   logic re;
   logic rclr;
   logic [row_addr_bits_c-1:0] raddr;
   logic [row_bits_c-1:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output wmask, output re, output rclr, output raddr,
      input rdata);
   modport mem (input we, input waddr, input wdata, input wmask, input re, input rclr, input raddr,
      output rdata);
endinterface

/* verilog/ram_array.sv */
// 32 x 18 storage array with bit write mask and registered read
`timescale 1ns/1ps
module ram_array #(
   parameter logic [ram_block_pkg::total_bits_c-1:0] init_image = '0
) (
   input wire logic clk,
   mem_port_if.mem port
);
   import ram_block_pkg::*;

   logic [row_bits_c-1:0] row_w;
   logic [row_bits_c-1:0] rdata_q = '0;

   // gather one bit column of the preload image
   function automatic logic [rows_c-1:0] column_of(input logic [total_bits_c-1:0] img, input int b);
      logic [rows_c-1:0] c;
      c = '0;
      for (int r = 0; r < rows_c; r++) begin
         c[r] = img[r*row_bits_c+b];
      end
      return c;
   endfunction

   // one column per bit so the mask gates each bit on its own
   for (genvar b = 0; b < row_bits_c; b++) begin : g_col
      logic [rows_c-1:0] col_q = column_of(init_image, b);
      always_ff @(posedge clk) begin
         if (port.we && port.wmask[b]) begin
            col_q[port.waddr] <= port.wdata[b];
         end
      end
      assign row_w[b] = col_q[port.raddr];
   end

   // read register; a same-edge write to the row returns old data
   always_ff @(posedge clk) begin
      if (port.rclr) begin
         rdata_q <= '0;
      end else if (port.re) begin
         rdata_q <= row_w;
      end
   end

   assign port.rdata = rdata_q;
endmodule

/* verilog/small_dual_port_ram_block.sv */
// small 576-bit memory block: ram, rom, fifo and shift register modes with apb configuration
//
// Behaviour
// - 576 storage bits including parity bits
// - word widths 1 to 18 over one array
// - write and read widths may differ, except in fifo and shift modes, which read at the write width
// - sdp, single-port, fifo, rom, shift register modes
// - preloaded contents present before first access
// - input clear immediate, bypassed output at next edge
// - output clear visible at once, no edge
// - write inputs share one selectable clock
// - read address, enable, output each selectable
// - output register bypassable, input registers never
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module small_dual_port_ram_block (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ram_block_pkg::paddr_bits_c-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic clk_en0,
   input wire logic clk_en1,
   input wire logic in_clr_n,
   input wire logic out_clr_n,
   input wire logic wren,
   input wire logic [ram_block_pkg::row_bits_c-1:0] wdata,
   input wire logic [ram_block_pkg::addr_bits_c-1:0] waddr,
   input wire logic [1:0] byte_en,
   input wire logic rden,
   input wire logic [ram_block_pkg::addr_bits_c-1:0] raddr,
   output logic [ram_block_pkg::row_bits_c-1:0] rd_data,
   output logic fifo_full,
   output logic fifo_empty
);
   import ram_block_pkg::*;

   mem_port_if mport ();

   logic [31:0] cfg_q;
   logic [31:0] prdata_q;
   mode_type mode;
   width_type wwidth;
   width_type rwidth;
   width_type rw_eff;
   logic cfg_write;
   logic in_rst_n;
   logic out_rst_n;
   logic wr_strobe;
   logic ra_strobe;
   logic re_strobe;
   logic out_strobe;
   logic bypass;
   logic wren_q;
   logic [row_bits_c-1:0] wdata_q;
   logic [addr_bits_c-1:0] waddr_q;
   logic [1:0] be_q;
   logic wr_go_q;
   logic [addr_bits_c-1:0] raddr_q;
   logic rden_q;
   logic rd_go_q;
   logic clr_pend_q;
   logic [addr_bits_c-1:0] wptr_q;
   logic [addr_bits_c-1:0] rptr_q;
   logic [count_bits_c-1:0] count_q;
   logic [count_bits_c-1:0] depth;
   logic push;
   logic pop;
   logic shift_go;
   logic do_write;
   logic do_read;
   logic [addr_bits_c-1:0] wa_eff;
   logic [addr_bits_c-1:0] ra_eff;
   logic [9:0] wloc;
   logic [9:0] rloc;
   logic [col_bits_c-1:0] rcol_q;
   width_type rw_q;
   logic [row_bits_c-1:0] wmask_d;
   logic [row_bits_c-1:0] wrow_d;
   logic [row_bits_c-1:0] rd_word;
   logic [row_bits_c-1:0] out_q;

   // bits per word of each organisation
   function automatic logic [4:0] width_of(input width_type w);
      case (w)
         w1: width_of = 5'h01;
         w2: width_of = 5'h02;
         w4: width_of = 5'h04;
         w8: width_of = 5'h08;
         w9: width_of = 5'h09;
         w16: width_of = 5'h10;
         default: width_of = 5'h12;
      endcase
   endfunction

   // shift from word index to bit index for the parity-free widths
   function automatic logic [2:0] lg_of(input width_type w);
      case (w)
         w2: lg_of = 3'h1;
         w4: lg_of = 3'h2;
         w8: lg_of = 3'h3;
         w16: lg_of = 3'h4;
         default: lg_of = 3'h0;
      endcase
   endfunction

   // number of words of each organisation
   function automatic logic [9:0] depth_of(input width_type w);
      case (w)
         w9: depth_of = depth_w9_c;
         w18: depth_of = depth_w18_c;
         default: depth_of = depth_narrow_c >> lg_of(w);
      endcase
   endfunction

   // word address to {row, first column}; parity-free widths count columns without the parity slots
   function automatic logic [9:0] locate(input width_type w, input logic [addr_bits_c-1:0] a);
      logic [12:0] b;
      b = 13'(a) << lg_of(w);
      case (w)
         w9: locate = {a[5:1], a[0] ? lane_split_c : 5'h00};
         w18: locate = {a[4:0], 5'h00};
         default: locate = {b[8:4], 1'b0, b[3:0]};
      endcase
   endfunction

   // physical bit of data bit j; parity-free widths skip the parity slots
   function automatic logic [4:0] phys_bit(input width_type w, input logic [4:0] col, input logic [4:0] j);
      logic [4:0] c;
      c = col + j;
      if (w == w9 || w == w18 || c < lane_data_bits_c) begin
         phys_bit = c;
      end else begin
         phys_bit = c + 5'h01;
      end
   endfunction

   // apb address decode
   function automatic logic is_mapped(input logic [paddr_bits_c-1:0] a);
      is_mapped = (a == cfg_addr_c) || (a == stat_addr_c);
   endfunction

   // configuration fields
   assign mode = mode_type'(cfg_q[cfg_mode_lsb_c +: $bits(mode_type)]);
   assign wwidth = width_type'(cfg_q[cfg_wwidth_lsb_c +: $bits(width_type)]);
   assign rwidth = width_type'(cfg_q[cfg_rwidth_lsb_c +: $bits(width_type)]);
   assign rw_eff = (mode == mode_fifo || mode == mode_shift) ? wwidth : rwidth;
   assign bypass = cfg_q[cfg_bypass_bit_c];

   // apb slave: zero wait states, error on unmapped access
   assign pready = 1'b1;
   assign pslverr = psel && penable && !is_mapped(paddr);
   assign cfg_write = psel && penable && pwrite && (paddr == cfg_addr_c);
   assign prdata = prdata_q;

   // configuration register with byte strobes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= cfg_reset_c;
      end else if (cfg_write) begin
         for (int i = 0; i < 4; i++) begin
            if (pstrb[i]) begin
               cfg_q[i*8 +: 8] <= pwdata[i*8 +: 8] & cfg_mask_c[i*8 +: 8];
            end
         end
      end
   end

   // read data captured in the setup phase so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (psel && !penable) begin
         prdata_q <= '0;
         if (paddr == cfg_addr_c) begin
            prdata_q <= cfg_q;
         end else if (paddr == stat_addr_c) begin
            prdata_q[stat_count_lsb_c +: count_bits_c] <= count_q;
            prdata_q[stat_empty_bit_c] <= fifo_empty;
            prdata_q[stat_full_bit_c] <= fifo_full;
         end
      end
   end

   // clears; gating the reset is safe as both sources are glitch-free fabric levels
   assign in_rst_n = presetn & in_clr_n;
   assign out_rst_n = presetn & out_clr_n;

   // pick one of the two block clocks for each register group
   assign wr_strobe = cfg_q[cfg_wsel_bit_c] ? clk_en1 : clk_en0;
   assign ra_strobe = cfg_q[cfg_rasel_bit_c] ? clk_en1 : clk_en0;
   assign re_strobe = cfg_q[cfg_resel_bit_c] ? clk_en1 : clk_en0;
   assign out_strobe = cfg_q[cfg_osel_bit_c] ? clk_en1 : clk_en0;

   // write-side input registers, never bypassed
   always_ff @(posedge pclk or negedge in_rst_n) begin
      if (!in_rst_n) begin
         wren_q <= 1'b0;
         wdata_q <= '0;
         waddr_q <= '0;
         be_q <= '0;
         wr_go_q <= 1'b0;
      end else begin
         wr_go_q <= wr_strobe;
         if (wr_strobe) begin
            wren_q <= wren;
            wdata_q <= wdata;
            waddr_q <= waddr;
            be_q <= byte_en;
         end
      end
   end

   // read-side input registers
   always_ff @(posedge pclk or negedge in_rst_n) begin
      if (!in_rst_n) begin
         raddr_q <= '0;
         rden_q <= 1'b0;
         rd_go_q <= 1'b0;
      end else begin
         rd_go_q <= re_strobe;
         if (ra_strobe) begin
            raddr_q <= raddr;
         end
         if (re_strobe) begin
            rden_q <= rden;
         end
      end
   end

   // holds the array read register cleared until the edge after an input clear
   always_ff @(posedge pclk or negedge in_rst_n) begin
      if (!in_rst_n) begin
         clr_pend_q <= 1'b1;
      end else begin
         clr_pend_q <= 1'b0;
      end
   end

   // fifo and shift bookkeeping
   assign depth = depth_of(wwidth);
   assign fifo_full = (mode == mode_fifo) && (count_q == depth);
   assign fifo_empty = (mode != mode_fifo) || (count_q == '0);
   assign push = (mode == mode_fifo) && wr_go_q && wren_q && !fifo_full;
   assign pop = (mode == mode_fifo) && rd_go_q && rden_q && !fifo_empty;
   assign shift_go = (mode == mode_shift) && wr_go_q && wren_q;

   // pointers restart whenever software reconfigures the block
   always_ff @(posedge pclk or negedge in_rst_n) begin
      if (!in_rst_n) begin
         wptr_q <= '0;
         rptr_q <= '0;
         count_q <= '0;
      end else if (cfg_write) begin
         wptr_q <= '0;
         rptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push || shift_go) begin
            wptr_q <= (10'(wptr_q) == depth - 10'h001) ? '0 : wptr_q + 9'h001;
         end
         if (pop) begin
            rptr_q <= (10'(rptr_q) == depth - 10'h001) ? '0 : rptr_q + 9'h001;
         end
         count_q <= count_q + count_bits_c'(push) - count_bits_c'(pop);
      end
   end

   // per-mode choice of access and addresses
   always_comb begin
      wa_eff = waddr_q;
      ra_eff = raddr_q;
      do_write = 1'b0;
      do_read = rd_go_q && rden_q;
      case (mode)
         mode_sdp: begin
            do_write = wr_go_q && wren_q;
         end
         mode_sp: begin
            do_write = wr_go_q && wren_q;
            ra_eff = waddr_q;
         end
         mode_fifo: begin
            do_write = push;
            do_read = pop;
            wa_eff = wptr_q;
            ra_eff = rptr_q;
         end
         mode_rom: begin
            do_write = 1'b0;
         end
         mode_shift: begin
            do_write = shift_go;
            do_read = shift_go;
            wa_eff = wptr_q;
            ra_eff = wptr_q;
         end
         default: begin
            do_write = 1'b0;
            do_read = 1'b0;
         end
      endcase
   end

   // spread the write word over the row; byte enables mask only the lane widths
   always_comb begin
      logic [4:0] p;
      p = '0;
      wloc = locate(wwidth, wa_eff);
      wmask_d = '0;
      wrow_d = '0;
      for (int j = 0; j < row_bits_c; j++) begin
         if (5'(j) < width_of(wwidth)) begin
            p = phys_bit(wwidth, wloc[col_bits_c-1:0], 5'(j));
            wmask_d[p] = (wwidth == w16 || wwidth == w18) ? be_q[p >= lane_split_c] : 1'b1;
            wrow_d[p] = wdata_q[j];
         end
      end
   end

   assign rloc = locate(rw_eff, ra_eff);
   assign mport.we = do_write;
   assign mport.waddr = wloc[9:col_bits_c];
   assign mport.wdata = wrow_d;
   assign mport.wmask = wmask_d;
   assign mport.re = do_read;
   assign mport.rclr = clr_pend_q;
   assign mport.raddr = rloc[9:col_bits_c];

   // remember where the read word sits in the row returned one edge later;
   // only presetn clears it, so an input clear cannot reshuffle a bypassed word before the next edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcol_q <= '0;
         rw_q <= w18;
      end else if (do_read) begin
         rcol_q <= rloc[col_bits_c-1:0];
         rw_q <= rw_eff;
      end
   end

   // pick the read word out of the row
   always_comb begin
      rd_word = '0;
      for (int j = 0; j < row_bits_c; j++) begin
         if (5'(j) < width_of(rw_q)) begin
            rd_word[j] = mport.rdata[phys_bit(rw_q, rcol_q, 5'(j))];
         end
      end
   end

   // output register, cleared at power-up and by the output clear
   always_ff @(posedge pclk or negedge out_rst_n) begin
      if (!out_rst_n) begin
         out_q <= '0;
      end else if (out_strobe) begin
         out_q <= rd_word;
      end
   end

   // bypass gives the unregistered path; output clear still forces zero at once
   assign rd_data = bypass ? (out_clr_n ? rd_word : '0) : out_q;

   ram_array #(
      .init_image(init_image_c)
   ) u_array (
      .clk(pclk),
      .port(mport)
   );
endmodule

/* dv/ram_block_sva.sv */
// port-level assertion checker for the small ram block
`timescale 1ns/1ps
module ram_block_sva
   import ram_block_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ram_block_pkg::paddr_bits_c-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic in_clr_n,
   input wire logic out_clr_n,
   input wire logic [ram_block_pkg::row_bits_c-1:0] rd_data,
   input wire logic fifo_full,
   input wire logic fifo_empty
);
   logic [31:0] cfg_q;
   logic [31:0] m;
   logic um;
   // strobe mask and unmapped decode
   assign m = cfg_mask_c & {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign um = paddr != cfg_addr_c && paddr != stat_addr_c;
   // config shadow, needed to know when the output register is bypassed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= cfg_reset_c;
      end else if (psel && penable && pwrite && paddr == cfg_addr_c) begin
         cfg_q <= (cfg_q & ~m) | (pwdata & m);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_s;
      psel && penable;
   endsequence
   sequence cfg_wr_s;
      acc_s ##0 (pwrite && paddr == cfg_addr_c);
   endsequence
   AST_READY: assert property (pready)
      else $error("pready low");
   AST_SLVERR: assert property (pslverr == (psel && penable && um))
      else $error("pslverr wrong");
   AST_ERR_DATA: assert property (acc_s ##0 um |-> prdata == 32'h0)
      else $error("unmapped read data not zero");
   AST_CFG_READ: assert property (acc_s ##0 (!pwrite && paddr == cfg_addr_c) |-> prdata == cfg_q)
      else $error("config readback wrong");
   AST_CFG_FIFO: assert property (cfg_wr_s |=> fifo_empty && !fifo_full)
      else $error("config write left fifo not empty");
   AST_FLAGS: assert property (!(fifo_full && fifo_empty))
      else $error("fifo full and empty together");
   AST_OUT_CLR: assert property (!out_clr_n |-> rd_data == '0)
      else $error("output clear not seen at once");
   AST_IN_CLR: assert property (!in_clr_n && cfg_q[cfg_bypass_bit_c] |=> rd_data == '0)
      else $error("input clear not seen after edge");
   AST_PWR_UP: assert property ($rose(presetn) |-> rd_data == '0 && fifo_empty && !fifo_full)
      else $error("outputs not cleared after reset");
endmodule
bind small_dual_port_ram_block ram_block_sva ram_block_sva_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .in_clr_n, .out_clr_n, .rd_data, .fifo_full, .fifo_empty);

/* dv/fabric_model.sv */
// fabric-side model driving enables, clears and both ports
`timescale 1ns/1ps
module fabric_model (
   input wire logic pclk,
   output logic clk_en0,
   output logic clk_en1,
   output logic in_clr_n,
   output logic out_clr_n,
   output logic wren,
   output logic [ram_block_pkg::row_bits_c-1:0] wdata,
   output logic [ram_block_pkg::addr_bits_c-1:0] waddr,
   output logic [1:0] byte_en,
   output logic rden,
   output logic [ram_block_pkg::addr_bits_c-1:0] raddr
);
   import ram_block_pkg::*;
   // quiet levels until traffic is asked for
   initial begin
      {clk_en0, clk_en1, wren, rden, wdata, waddr, byte_en, raddr} = '0;
      {in_clr_n, out_clr_n} = 2'b11;
   end
   // one word on the chosen enable after g idle cycles
   task automatic push(input bit s, input logic [addr_bits_c-1:0] a, input logic [row_bits_c-1:0] d,
      input logic [1:0] b, input int g);
      repeat (g) @(posedge pclk);
      @(posedge pclk);
      clk_en0 <= !s;
      clk_en1 <= s;
      wren <= 1'b1;
      waddr <= a;
      wdata <= d;
      byte_en <= b;
      @(posedge pclk);
      {clk_en0, clk_en1, wren} <= 3'b000;
      wdata <= ~d; // released data must not look valid
   endtask
   // one read, enable held over address, array and output stages
   task automatic pull(input bit s, input logic [addr_bits_c-1:0] a, input int g);
      repeat (g) @(posedge pclk);
      @(posedge pclk);
      clk_en0 <= !s;
      clk_en1 <= s;
      rden <= 1'b1;
      raddr <= a;
      @(posedge pclk);
      rden <= 1'b0;
      repeat (2) @(posedge pclk);
      {clk_en0, clk_en1} <= 2'b00;
      raddr <= ~a;
   endtask
   task automatic set_clr(input logic i, input logic o);
      @(posedge pclk);
      in_clr_n <= i;
      out_clr_n <= o;
   endtask
endmodule

/* dv/tb.sv */
// self-checking bench for the small dual-port ram block
`timescale 1ns/1ps
module tb;
   import ram_block_pkg::*;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [paddr_bits_c-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = '0;
   logic pready, pslverr, clk_en0, clk_en1, in_clr_n, out_clr_n, wren, rden, fifo_full, fifo_empty, e;
   logic [31:0] prdata, r, d;
   logic [row_bits_c-1:0] wdata, rd_data;
   logic [addr_bits_c-1:0] waddr, raddr;
   logic [1:0] byte_en;
   logic [total_bits_c-1:0] mem = init_image_c;
   logic [17:0] q[$];
   integer seed = 32'h6d553447;
   int err_count = 0;
   int n_checks = 0;
   int wc, rc, a, w;
   always #25 pclk = ~pclk;
   small_dual_port_ram_block small_dual_port_ram_block_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .pready, .prdata, .pslverr, .clk_en0, .clk_en1, .in_clr_n, .out_clr_n, .wren, .wdata,
      .waddr, .byte_en, .rden, .raddr, .rd_data, .fifo_full, .fifo_empty);
   fabric_model fabric_model_i (.pclk, .clk_en0, .clk_en1, .in_clr_n, .out_clr_n, .wren, .wdata, .waddr,
      .byte_en, .rden, .raddr);
   function automatic int wid(input int c);
      return c > 5 ? 18 : c == 5 ? 16 : c == 4 ? 9 : 1 << c;
   endfunction
   function automatic int dep(input int w);
      return w == 18 ? 32 : w == 9 ? 64 : 512 / w;
   endfunction
   // narrow words skip the parity bits 8 and 17 of a row
   function automatic int ph(input int a, input int w, input int i);
      int l;
      l = a * w + i;
      return w % 9 == 0 ? l : l / 16 * 18 + l % 16 + (l % 16 > 7);
   endfunction
   function automatic logic [31:0] ex(input int a, input int w);
      logic [31:0] v;
      v = '0;
      for (int i = 0; i < w; i++) v[i] = mem[ph(a, w, i)];
      return v;
   endfunction
   // model write, lanes masked only for the wide words
   task automatic mw(input int a, input int w, input logic [17:0] x, input logic [1:0] be);
      for (int i = 0; i < w; i++) if (w < 16 || be[i / (w == 18 ? 9 : 8)]) mem[ph(a, w, i)] = x[i];
   endtask
   task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, x, g);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // apb transfer; waits for pready, 20 cycles at most
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_count++;
         end_sim;
      end
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk("rd_data", rd_data, 0);
      chk("flags", {fifo_full, fifo_empty}, 2'b01);
      apb(0, cfg_addr_c, 0);
      chk("config", r, cfg_reset_c);
      apb(1, stat_addr_c, 32'hffff_ffff);
      apb(0, stat_addr_c, 0);
      chk("status", r, 32'h0001_0000);
      apb(0, 12'h008, 0);
      chk("slverr", e, 1);
      chk("unmapped", r, 0);
      fabric_model_i.pull(0, 0, 0);
      #1 chk("preload", rd_data, ex(0, 18));
      // every row filled, parity bits included
      for (a = 0; a < 32; a++) begin
         d = $random(seed);
         fabric_model_i.push(0, a[8:0], d[17:0], 2'b11, int'(d[19:18]));
         mw(a, 18, d[17:0], 2'b11);
      end
      // random write and read widths over one array
      for (int k = 0; k < 40; k++) begin
         wc = {$random(seed)} % 7;
         rc = {$random(seed)} % 7;
         w = wid(wc);
         a = {$random(seed)} % dep(w);
         d = $random(seed);
         apb(1, cfg_addr_c, wc << 4 | wc << 8);
         fabric_model_i.push(0, a[8:0], d[17:0], d[21:20], int'(d[19:18]));
         mw(a, w, d[17:0], d[21:20]);
         fabric_model_i.pull(0, a[8:0], 0);
         #1 chk("same width", rd_data, ex(a, w));
         apb(1, cfg_addr_c, wc << 4 | rc << 8);
         a = {$random(seed)} % dep(wid(rc));
         fabric_model_i.pull(0, a[8:0], int'(d[23:22]));
         #1 chk("mixed width", rd_data, ex(a, wid(rc)));
      end
      apb(1, cfg_addr_c, 32'h0000_0663);
      fabric_model_i.push(0, 5, 18'h15a5a, 2'b11, 0);
      fabric_model_i.pull(0, 5, 0);
      #1 chk("rom", rd_data, ex(5, 18));
      // single port reads at the registered write address, not raddr
      apb(1, cfg_addr_c, 32'h0000_0661);
      d = $random(seed);
      fabric_model_i.push(0, 11, d[17:0], 2'b11, 0);
      mw(11, 18, d[17:0], 2'b11);
      fabric_model_i.pull(0, 3, 0);
      #1 chk("single port", rd_data, ex(11, 18));
      // shift register hands back the old word at each write pointer
      apb(1, cfg_addr_c, 32'h0001_0664);
      for (a = 0; a < 3; a++) begin
         d = $random(seed);
         fabric_model_i.push(0, 0, d[17:0], 2'b11, 0);
         @(posedge pclk);
         #1 chk("shift", rd_data, ex(a, 18));
         mw(a, 18, d[17:0], 2'b11);
      end
      // write group and read side each on either enable
      for (int s = 0; s < 4; s++) begin
         apb(1, cfg_addr_c, 32'h660 | (s & 1) << 12 | (s >> 1) * 32'h0000_e000);
         d = $random(seed);
         fabric_model_i.push(!s[0], 9, d[17:0], 2'b11, 0);
         fabric_model_i.push(s[0], 7, d[17:0], 2'b11, 0);
         mw(7, 18, d[17:0], 2'b11);
         fabric_model_i.pull(s[1], 9, 0);
         #1 chk("other enable", rd_data, ex(9, 18));
         fabric_model_i.pull(s[1], 7, 0);
         #1 chk("own enable", rd_data, ex(7, 18));
      end
      // input clear reaches a bypassed output one edge late
      apb(1, cfg_addr_c, 32'h0001_0660);
      fabric_model_i.pull(0, 7, 0);
      fabric_model_i.set_clr(0, 1);
      #1 chk("in clear early", rd_data, ex(7, 18));
      @(posedge pclk);
      #1 chk("in clear late", rd_data, 0);
      fabric_model_i.set_clr(1, 1);
      apb(1, cfg_addr_c, 32'h660);
      fabric_model_i.pull(0, 7, 0);
      fabric_model_i.set_clr(1, 0);
      #1 chk("out clear", rd_data, 0);
      fabric_model_i.set_clr(1, 1);
      // fifo pushed past full, then drained in order
      apb(1, cfg_addr_c, 32'h662);
      for (a = 0; a < 33; a++) begin
         d = $random(seed);
         fabric_model_i.push(0, 0, d[17:0], 2'b11, int'(d[19:18]));
         if (a < 32) q.push_back(d[17:0]);
      end
      apb(0, stat_addr_c, 0);
      chk("fifo full", r, 32'h0002_0020);
      while (q.size() > 0) begin
         fabric_model_i.pull(0, 0, 0);
         #1 chk("fifo data", rd_data, q.pop_front());
      end
      apb(0, stat_addr_c, 0);
      chk("fifo empty", r, 32'h0001_0000);
      end_sim;
   end
endmodule
